// ### rtl/ccd_div_if.sv
/*
 * Carrier between the register block and one divider: settings in,
 * divided level out.
 * Assumes both ends run on the divider input clock.
 */
`timescale 1ns/1ps
interface ccd_div_if;
   import ccd_pkg::*;
   logic [CNT_W-1:0] low_cnt;
   logic [CNT_W-1:0] high_cnt;
   logic [CNT_W-1:0] phase;
   logic             ignore_sync;
   logic             force_high;
   logic             start_high;
   logic             sync_req;
   logic             div_level;
   modport div (input low_cnt, high_cnt, phase, ignore_sync, force_high, start_high, sync_req, output div_level);
   modport ctl (output low_cnt, high_cnt, phase, ignore_sync, force_high, start_high, sync_req, input div_level);
endinterface

// ### rtl/ccd_divider.sv
/*
 * One divider core: hold, phase-offset delay and low/high counting.
 * Assumes its settings are stable registers on the same clock.
 */
`timescale 1ns/1ps
module ccd_divider (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Settings and output
   ccd_div_if.div   d
);
   import ccd_pkg::*;

   ccd_state_type    state;
   ccd_state_type    next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             level;
   logic             next_level;
   logic             sync_act;

   // Terminal count of the phase now being output.
   function automatic logic [CNT_W-1:0] phase_limit(input logic lvl, input logic [CNT_W-1:0] lo,
                                                    input logic [CNT_W-1:0] hi);
      return lvl ? hi : lo;
   endfunction

   // =========================================================================
   // Next-state logic.
   always_comb begin
      sync_act   = d.sync_req && !d.ignore_sync;
      next_state = state;
      next_cnt   = cnt;
      next_level = level;
      if (sync_act) begin
         // An obeyed alignment request restarts the divider at its start level.
         next_state = CCD_HOLD;
         next_cnt   = CNT_ZERO;
         next_level = d.start_high;
      end else begin
         case (state)
            CCD_HOLD: begin
               if (d.ignore_sync) begin
                  next_level = d.force_high;
               end else if (d.phase == CNT_ZERO) begin
                  next_state = CCD_RUN;
                  next_cnt   = CNT_ZERO;
                  next_level = d.start_high;
               end else begin
                  next_state = CCD_PHASE;
                  next_cnt   = d.phase;
                  next_level = d.start_high;
               end
            end
            CCD_PHASE: begin
               // The level stays put for exactly phase cycles before counting.
               if (cnt == CNT_ONE) begin
                  next_state = CCD_RUN;
                  next_cnt   = CNT_ZERO;
               end else begin
                  next_cnt = cnt - CNT_ONE;
               end
            end
            CCD_RUN: begin
               if (cnt == phase_limit(level, d.low_cnt, d.high_cnt)) begin
                  next_level = !level;
                  next_cnt   = CNT_ZERO;
               end else begin
                  next_cnt = cnt + CNT_ONE;
               end
            end
            default: begin
               next_state = CCD_HOLD;
               next_cnt   = CNT_ZERO;
            end
         endcase
      end
   end

   // =========================================================================
   // State registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= CCD_HOLD;
         cnt   <= CNT_ZERO;
         level <= 1'b0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         level <= next_level;
      end
   end

   assign d.div_level = level;

   // =========================================================================
   // Checks.
   sequence s_released;
      state == CCD_HOLD && !d.sync_req && !d.ignore_sync;
   endsequence

   property p_low_len;
      @(posedge core_clk) disable iff (!rst_n)
      state == CCD_RUN && !level && !d.sync_req && cnt < d.low_cnt |=> !level && cnt == $past(cnt) + CNT_ONE;
   endproperty
   a_low_len: assert property (p_low_len) else $error("Low phase ended early.");

   property p_low_end;
      @(posedge core_clk) disable iff (!rst_n)
      state == CCD_RUN && !level && !d.sync_req && cnt == d.low_cnt |=> level && cnt == CNT_ZERO;
   endproperty
   a_low_end: assert property (p_low_end) else $error("Low phase did not end on count.");

   property p_high_end;
      @(posedge core_clk) disable iff (!rst_n)
      state == CCD_RUN && level && !d.sync_req && cnt == phase_limit(level, d.low_cnt, d.high_cnt)
      |=> !level ##1 (!level || $past(d.low_cnt) == CNT_ZERO || $past(d.sync_req));
   endproperty
   a_high_end: assert property (p_high_end) else $error("High phase did not end on count.");

   property p_sync_hold;
      @(posedge core_clk) disable iff (!rst_n)
      d.sync_req && !d.ignore_sync |=> state == CCD_HOLD && level == $past(d.start_high);
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("Alignment did not restart divider.");

   property p_force;
      @(posedge core_clk) disable iff (!rst_n)
      state == CCD_HOLD && d.ignore_sync |=> state == CCD_HOLD && level == $past(d.force_high);
   endproperty
   a_force: assert property (p_force) else $error("Forced level not applied.");

   property p_release;
      @(posedge core_clk) disable iff (!rst_n)
      s_released |=> level == $past(d.start_high) &&
                     state == (($past(d.phase) == CNT_ZERO) ? CCD_RUN : CCD_PHASE);
   endproperty
   a_release: assert property (p_release) else $error("Release went to wrong state.");

   property p_phase_wait;
      @(posedge core_clk) disable iff (!rst_n)
      state == CCD_PHASE && cnt > CNT_ONE && !d.sync_req |=> state == CCD_PHASE && $stable(level);
   endproperty
   a_phase_wait: assert property (p_phase_wait) else $error("Phase offset cut short.");
endmodule

// ### rtl/ccd_pkg.sv
/*
 * Constants shared by the channel clock divider: register offsets, field
 * positions, reset values and the divider state enumeration.
 * Assumes an 8-bit register port with a 10-bit address.
 */
package ccd_pkg;
   // =========================================================================
   // Widths
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int CNT_W  = 4;

   // =========================================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] A_DIV0_COUNTS = 10'h190;
   localparam logic [ADDR_W-1:0] A_DIV0_OPTS   = 10'h191;
   localparam logic [ADDR_W-1:0] A_CH0_PWR     = 10'h192;
   localparam logic [ADDR_W-1:0] A_DIV1_COUNTS = 10'h193;
   localparam logic [ADDR_W-1:0] A_DIV1_OPTS   = 10'h194;

   // =========================================================================
   // Field positions
   localparam int LOW_HI      = 7;
   localparam int LOW_LO      = 4;
   localparam int HIGH_HI     = 3;
   localparam int HIGH_LO     = 0;
   localparam int BYP_BIT     = 7;
   localparam int IGN_BIT     = 6;
   localparam int FORCE_BIT   = 5;
   localparam int START_BIT   = 4;
   localparam int PHASE_HI    = 3;
   localparam int PHASE_LO    = 0;
   localparam int PD_BIT      = 2;
   localparam int DCC_OFF_BIT = 0;

   // =========================================================================
   // Reset values
   localparam logic [DATA_W-1:0] DIV0_COUNTS_RST = 8'h77;
   localparam logic [DATA_W-1:0] DIV1_COUNTS_RST = 8'h33;
   localparam logic [DATA_W-1:0] OPTS_RST        = 8'h00;
   localparam logic [DATA_W-1:0] PWR_RST         = 8'h00;
   localparam logic [CNT_W-1:0]  CNT_ZERO        = 4'h0;
   localparam logic [CNT_W-1:0]  CNT_ONE         = 4'h1;

   // =========================================================================
   // Divider states
   typedef enum logic [1:0] {CCD_HOLD, CCD_PHASE, CCD_RUN} ccd_state_type;
endpackage

// ### rtl/ccd_top.sv
/*
 * Channel clock divider block: register file for divider 0, channel 0
 * power and correction, and divider 1, plus the two divider cores.
 * Assumes core_clk is the distribution input clock and register writes
 * arrive synchronous to it.
 */
`timescale 1ns/1ps
module ccd_top (
   // Clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   // Register port
   input  wire logic [ccd_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [ccd_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                       reg_write,
   output logic      [ccd_pkg::DATA_W-1:0] reg_rdata,
   // Chip-level alignment request
   input  wire logic                       sync_req,
   // Divider outputs
   output logic                            div0_clk,
   output logic                            div1_clk,
   // Channel 0 drivers
   output logic                            channel0_driver_a,
   output logic                            channel0_driver_a_oe,
   output logic                            channel0_driver_b,
   output logic                            channel0_driver_b_oe,
   output logic                            channel0_driver_c,
   output logic                            channel0_driver_c_oe,
   // Duty-cycle correction enable
   output logic                            duty_cycle_fix
);
   import ccd_pkg::*;

   logic [DATA_W-1:0] divider0_phase_counts;
   logic [DATA_W-1:0] divider0_options;
   logic [DATA_W-1:0] channel0_power_and_correction;
   logic [DATA_W-1:0] divider1_phase_counts;
   logic [DATA_W-1:0] divider1_options;
   logic [DATA_W-1:0] next_divider0_phase_counts;
   logic [DATA_W-1:0] next_divider0_options;
   logic [DATA_W-1:0] next_channel0_power_and_correction;
   logic [DATA_W-1:0] next_divider1_phase_counts;
   logic [DATA_W-1:0] next_divider1_options;
   logic [DATA_W-1:0] next_reg_rdata;
   logic              wr_seen;
   logic              next_wr_seen;

   ccd_div_if d0 ();
   ccd_div_if d1 ();

   // =========================================================================
   // Register file. Only implemented bits of the power register are stored,
   // so its reserved bits read back as zero without extra masking.
   always_comb begin
      next_divider0_phase_counts         = divider0_phase_counts;
      next_divider0_options              = divider0_options;
      next_channel0_power_and_correction = channel0_power_and_correction;
      next_divider1_phase_counts         = divider1_phase_counts;
      next_divider1_options              = divider1_options;
      next_wr_seen                       = wr_seen || reg_write;
      if (reg_write) begin
         case (reg_addr)
            A_DIV0_COUNTS: next_divider0_phase_counts = reg_wdata;
            A_DIV0_OPTS:   next_divider0_options      = reg_wdata;
            A_CH0_PWR: begin
               next_channel0_power_and_correction              = PWR_RST;
               next_channel0_power_and_correction[PD_BIT]      = reg_wdata[PD_BIT];
               next_channel0_power_and_correction[DCC_OFF_BIT] = reg_wdata[DCC_OFF_BIT];
            end
            A_DIV1_COUNTS: next_divider1_phase_counts = reg_wdata;
            A_DIV1_OPTS:   next_divider1_options      = reg_wdata;
            default:       next_wr_seen               = wr_seen || reg_write;
         endcase
      end
   end

   // Register storage; field defaults are the reset state.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         divider0_phase_counts         <= DIV0_COUNTS_RST;
         divider0_options              <= OPTS_RST;
         channel0_power_and_correction <= PWR_RST;
         divider1_phase_counts         <= DIV1_COUNTS_RST;
         divider1_options              <= OPTS_RST;
         wr_seen                       <= 1'b0;
      end else begin
         divider0_phase_counts         <= next_divider0_phase_counts;
         divider0_options              <= next_divider0_options;
         channel0_power_and_correction <= next_channel0_power_and_correction;
         divider1_phase_counts         <= next_divider1_phase_counts;
         divider1_options              <= next_divider1_options;
         wr_seen                       <= next_wr_seen;
      end
   end

   // =========================================================================
   // Read path. Data is registered so it appears one cycle after the address;
   // an unmapped address returns zero.
   always_comb begin
      case (reg_addr)
         A_DIV0_COUNTS: next_reg_rdata = divider0_phase_counts;
         A_DIV0_OPTS:   next_reg_rdata = divider0_options;
         A_CH0_PWR:     next_reg_rdata = channel0_power_and_correction;
         A_DIV1_COUNTS: next_reg_rdata = divider1_phase_counts;
         A_DIV1_OPTS:   next_reg_rdata = divider1_options;
         default:       next_reg_rdata = '0;
      endcase
   end

   // Read data register.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

   // =========================================================================
   // Divider settings.
   assign d0.low_cnt     = divider0_phase_counts[LOW_HI:LOW_LO];
   assign d0.high_cnt    = divider0_phase_counts[HIGH_HI:HIGH_LO];
   assign d0.phase       = divider0_options[PHASE_HI:PHASE_LO];
   assign d0.ignore_sync = divider0_options[IGN_BIT];
   assign d0.force_high  = divider0_options[FORCE_BIT];
   assign d0.start_high  = divider0_options[START_BIT];
   assign d0.sync_req    = sync_req;
   assign d1.low_cnt     = divider1_phase_counts[LOW_HI:LOW_LO];
   assign d1.high_cnt    = divider1_phase_counts[HIGH_HI:HIGH_LO];
   assign d1.phase       = divider1_options[PHASE_HI:PHASE_LO];
   assign d1.ignore_sync = divider1_options[IGN_BIT];
   assign d1.force_high  = divider1_options[FORCE_BIT];
   assign d1.start_high  = divider1_options[START_BIT];
   assign d1.sync_req    = sync_req;

   ccd_divider u_div0 (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (d0.div)
   );

   ccd_divider u_div1 (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (d1.div)
   );

   // =========================================================================
   // Output routing. Bypass muxes the raw input clock onto the output; the
   // mux is a clock path and must be glitch-safe in the physical build.
   assign div0_clk = divider0_options[BYP_BIT] ? core_clk : d0.div_level;
   assign div1_clk = divider1_options[BYP_BIT] ? core_clk : d1.div_level;

   // Power-down releases all three drivers of channel 0 together.
   assign channel0_driver_a    = div0_clk;
   assign channel0_driver_b    = div0_clk;
   assign channel0_driver_c    = div0_clk;
   assign channel0_driver_a_oe = !channel0_power_and_correction[PD_BIT];
   assign channel0_driver_b_oe = !channel0_power_and_correction[PD_BIT];
   assign channel0_driver_c_oe = !channel0_power_and_correction[PD_BIT];
   assign duty_cycle_fix       = !channel0_power_and_correction[DCC_OFF_BIT];

   // =========================================================================
   // Checks.
   property p_defaults;
      @(posedge core_clk) disable iff (!rst_n)
      !wr_seen |-> divider0_phase_counts == DIV0_COUNTS_RST && divider1_phase_counts == DIV1_COUNTS_RST &&
                   divider0_options[PHASE_HI:PHASE_LO] == CNT_ZERO;
   endproperty
   a_defaults: assert property (p_defaults) else $error("Register defaults wrong.");

   property p_power_down;
      @(posedge core_clk) disable iff (!rst_n)
      reg_write && reg_addr == A_CH0_PWR && reg_wdata[PD_BIT] |=>
         !channel0_driver_a_oe && !channel0_driver_b_oe && !channel0_driver_c_oe;
   endproperty
   a_power_down: assert property (p_power_down) else $error("Drivers not released on power-down.");

   property p_dcc;
      @(posedge core_clk) disable iff (!rst_n)
      reg_write && reg_addr == A_CH0_PWR |=> duty_cycle_fix == !$past(reg_wdata[DCC_OFF_BIT]);
   endproperty
   a_dcc: assert property (p_dcc) else $error("Duty correction enable wrong.");

   // Divider 0 count and divider 1 option writes land whole, reserved bits stay clear and outputs follow the dividers.
   property p_write_counts;
      @(posedge core_clk) disable iff (!rst_n)
      reg_write && reg_addr == A_DIV0_COUNTS |=> divider0_phase_counts == $past(reg_wdata);
   endproperty
   a_write_counts: assert property (p_write_counts) else $error("Count write did not land.");

   property p_write_opts;
      @(posedge core_clk) disable iff (!rst_n)
      reg_write && reg_addr == A_DIV1_OPTS |=> divider1_options == $past(reg_wdata);
   endproperty
   a_write_opts: assert property (p_write_opts) else $error("Option write did not land.");

   property p_reserved_zero;
      @(posedge core_clk) disable iff (!rst_n)
      reg_addr == A_CH0_PWR |=> reg_rdata[DATA_W-1:PD_BIT+1] == '0 && reg_rdata[DCC_OFF_BIT+1] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits read nonzero.");

   property p_div0_route;
      @(posedge core_clk) disable iff (!rst_n)
      !divider0_options[BYP_BIT] |-> div0_clk == d0.div_level && channel0_driver_a == div0_clk;
   endproperty
   a_div0_route: assert property (p_div0_route) else $error("Divider 0 output misrouted.");

   property p_div1_route;
      @(posedge core_clk) disable iff (!rst_n)
      !divider1_options[BYP_BIT] |-> div1_clk == d1.div_level;
   endproperty
   a_div1_route: assert property (p_div1_route) else $error("Divider 1 output misrouted.");
endmodule

// ### test/ccd_top_tb.sv
/*
 * Self-checking testbench for the channel clock divider top level.
 * Assumes the rtl/ package, carrier, divider cores and top level, and a 40 MHz core_clk.
 */
`timescale 1ns/1ps
module ccd_top_tb;
   import ccd_pkg::*;
   // =========================================================================
   // Signals
   logic              core_clk;
   logic              rst_n;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_write;
   logic [DATA_W-1:0] reg_rdata;
   logic              sync_req;
   logic              div0_clk;
   logic              div1_clk;
   logic              drv_a;
   logic              drv_a_oe;
   logic              drv_b;
   logic              drv_b_oe;
   logic              drv_c;
   logic              drv_c_oe;
   logic              duty_cycle_fix;
   int                failures;
   int                n_tests;

   ccd_top DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_rdata(reg_rdata), .sync_req(sync_req), .div0_clk(div0_clk),
      .div1_clk(div1_clk), .channel0_driver_a(drv_a), .channel0_driver_a_oe(drv_a_oe),
      .channel0_driver_b(drv_b), .channel0_driver_b_oe(drv_b_oe), .channel0_driver_c(drv_c),
      .channel0_driver_c_oe(drv_c_oe), .duty_cycle_fix(duty_cycle_fix));

   // =========================================================================
   // Clock and watchdog
   // The clock period is 25 ns; the watchdog cuts a hang short well inside the run budget.
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (60000) @(posedge core_clk);
      bail();
   end

   // =========================================================================
   // Common tasks
   task automatic give_verdict();
      if (failures == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bail();
      failures = failures + 1;
      give_verdict();
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         failures = failures + 1;
      end
   endtask
   // Inputs move on falling edges only, so every rising edge sees settled values.
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge core_clk);
      reg_write = 1'b0;
      // One idle cycle, so a following call never raises the strobe in the step that lowered it.
      @(negedge core_clk);
   endtask
   // Read data is registered, so it is taken one cycle after the address is set.
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      reg_addr = a;
      @(negedge core_clk);
      d = reg_rdata;
   endtask
   function automatic logic lvl(input bit w);
      return w ? div1_clk : div0_clk;
   endfunction
   task automatic count_level(input bit w, input logic v, output int n);
      n = 0;
      while (lvl(w) === v) begin
         @(negedge core_clk);
         n = n + 1;
         if (n > 200) bail();
      end
   endtask
   // Align to a fresh falling output edge so a half phase cut by a write is never counted.
   task automatic measure(input bit w, output int lo, output int hi);
      int n;
      count_level(w, 1'b0, n);
      count_level(w, 1'b1, n);
      count_level(w, 1'b0, lo);
      count_level(w, 1'b1, hi);
   endtask

   // =========================================================================
   // Scenarios
   task automatic t_reset_values();
      logic [DATA_W-1:0] r;
      rd(A_DIV0_COUNTS, r); check(r, 8'h77);
      rd(A_DIV0_OPTS, r);   check(r, 8'h00);
      rd(A_CH0_PWR, r);     check(r, 8'h00);
      rd(A_DIV1_COUNTS, r); check(r, 8'h33);
      rd(A_DIV1_OPTS, r);   check(r, 8'h00);
      check({5'h00, drv_a_oe, drv_b_oe, drv_c_oe}, 8'h07);
      check({7'h00, duty_cycle_fix}, 8'h01);
   endtask
   task automatic t_periods();
      int lo;
      int hi;
      logic [7:0] tbl [3];
      tbl = '{8'h20, 8'hF0, 8'h0F};
      measure(1'b0, lo, hi);
      check(lo[7:0], 8'h08); check(hi[7:0], 8'h08);
      measure(1'b1, lo, hi);
      check(lo[7:0], 8'h04); check(hi[7:0], 8'h04);
      // Boundary counts: one cycle and sixteen cycles in each phase.
      foreach (tbl[i]) begin
         wr(A_DIV0_COUNTS, tbl[i]);
         measure(1'b0, lo, hi);
         check(lo[7:0], {4'h0, tbl[i][7:4]} + 8'h01);
         check(hi[7:0], {4'h0, tbl[i][3:0]} + 8'h01);
      end
      wr(A_DIV0_COUNTS, 8'h77);
   endtask
   task automatic t_bypass();
      wr(A_DIV0_OPTS, 8'h80);
      wr(A_DIV1_OPTS, 8'h80);
      repeat (3) begin
         // Step off the clock edge so the combinational bypass path has settled.
         #1;
         check({6'h00, div0_clk, div1_clk}, 8'h00);
         @(posedge core_clk);
         #1;
         check({6'h00, div0_clk, div1_clk}, 8'h03);
         @(negedge core_clk);
      end
      wr(A_DIV0_OPTS, 8'h00);
      wr(A_DIV1_OPTS, 8'h00);
   endtask
   // Divider 0 obeys a held alignment request while divider 1 ignores it and keeps running.
   task automatic t_sync();
      int rises;
      logic prev;
      rises = 0;
      wr(A_DIV1_OPTS, 8'h40);
      sync_req = 1'b1;
      @(negedge core_clk);
      prev = div1_clk;
      repeat (20) begin
         @(negedge core_clk);
         check({7'h00, div0_clk}, 8'h00);
         if (div1_clk === 1'b1 && prev === 1'b0) rises = rises + 1;
         prev = div1_clk;
      end
      check((rises >= 2) ? 8'h01 : 8'h00, 8'h01);
      sync_req = 1'b0;
      wr(A_DIV1_OPTS, 8'h00);
   endtask
   // The start level is held through the offset, so its length grows by exactly the offset.
   task automatic t_phase();
      int n [2];
      int lo;
      logic [DATA_W-1:0] r;
      wr(A_DIV0_COUNTS, 8'h11);
      for (int i = 0; i < 2; i++) begin
         wr(A_DIV0_OPTS, (i == 1) ? 8'h13 : 8'h10);
         sync_req = 1'b1;
         repeat (3) @(negedge core_clk);
         check({7'h00, div0_clk}, 8'h01);
         sync_req = 1'b0;
         count_level(1'b0, 1'b1, n[i]);
         count_level(1'b0, 1'b0, lo);
         check(lo[7:0], 8'h02);
      end
      check(8'(n[1] - n[0]), 8'h03);
      rd(A_DIV0_OPTS, r); check(r, 8'h13);
      wr(A_DIV0_OPTS, 8'h00);
      wr(A_DIV0_COUNTS, 8'h77);
   endtask
   task automatic t_force();
      sync_req = 1'b1;
      @(negedge core_clk);
      wr(A_DIV0_OPTS, 8'h60);
      sync_req = 1'b0;
      @(negedge core_clk);
      repeat (20) begin
         @(negedge core_clk);
         check({7'h00, div0_clk}, 8'h01);
      end
      wr(A_DIV0_OPTS, 8'h40);
      @(negedge core_clk);
      repeat (20) begin
         @(negedge core_clk);
         check({7'h00, div0_clk}, 8'h00);
      end
      wr(A_DIV0_OPTS, 8'h00);
   endtask
   task automatic t_power();
      logic [DATA_W-1:0] r;
      logic [7:0] pw [3];
      pw = '{8'h04, 8'h01, 8'hFF};
      foreach (pw[i]) begin
         wr(A_CH0_PWR, pw[i]);
         @(negedge core_clk);
         check({5'h00, drv_a_oe, drv_b_oe, drv_c_oe}, pw[i][2] ? 8'h00 : 8'h07);
         check({7'h00, duty_cycle_fix}, {7'h00, ~pw[i][0]});
         check({5'h00, drv_a, drv_b, drv_c}, {5'h00, {3{div0_clk}}});
      end
      rd(A_CH0_PWR, r); check(r, 8'h05);
      wr(A_CH0_PWR, 8'h00);
      // An unmapped write must leave the divider 0 count register alone and read back zero.
      wr(10'h195, 8'hAA);
      rd(10'h195, r); check(r, 8'h00);
      rd(A_DIV0_COUNTS, r); check(r, 8'h77);
   endtask

   // =========================================================================
   // Main sequence
   initial begin
      failures  = 0;
      n_tests   = 0;
      rst_n     = 1'b0;
      reg_addr  = '0;
      reg_wdata = '0;
      reg_write = 1'b0;
      sync_req  = 1'b0;
      do_reset();
      t_reset_values();
      t_periods();
      t_bypass();
      t_sync();
      t_phase();
      t_force();
      t_power();
      // A second reset in mid-run must restore every default.
      wr(A_DIV1_COUNTS, 8'h5A);
      wr(A_CH0_PWR, 8'h05);
      do_reset();
      t_reset_values();
      give_verdict();
   end
endmodule
